// >>> core/node_address_and_status_led.sv
// How it works
// - Only node addresses 1 through 64 count as valid.
// - Address is ten times upper digit (0-6) plus lower digit (0-9).
// - Address 00 and 65 through 69 are flagged invalid.
// - With an invalid address the node takes no part in the network.
// - Switches are read once at power-up; later changes are ignored.
// - Address is never stored; every power-up reads the switches again.
// - Each blink lasts 200 ms except the 80 ms fast flash; error LED sequences are separated by 1 s off.
// - Steady blinking alternates 200 ms on and 200 ms off without gap.
// - Blink-N gives N 200 ms pulses, 200 ms apart, then 1 s off, repeating.
// - Network LED stays dark while the peer processor is not working.
// - Network LED flashes every 160 ms while the fieldbus is error free.
// - Listen-only: receive without sending; network LED flashes once per second.
// - Token seen but never received: two flashes then 2 s off.
// - No other node or bad receiver: three flashes then 1.7 s off.
// - Duplicate address: four flashes then 1.4 s off.
// - Power indicator is lit whenever logic power is present.
// - Error LED shows detection of an island error.
// - Test LED follows software command alone.
`timescale 1ns/1ps

module node_address_and_status_led
    import node_led_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS_P = node_led_pkg::CYCLES_PER_MS
) (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [node_led_pkg::PADDR_W-1:0] paddr,
    input  wire logic [31:0]                      pwdata,
    output logic [31:0]                           prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic [3:0]                       switch_tens,
    input  wire logic [3:0]                       switch_ones,
    input  wire logic                             peer_ok,
    input  wire logic                             bus_ok,
    input  wire logic                             listen_only_state,
    input  wire logic                             token_not_received,
    input  wire logic                             no_other_node,
    input  wire logic                             duplicate_address,
    input  wire logic [3:0]                       island_error_code,
    output logic [6:0]                            node_address,
    output logic                                  address_valid,
    output logic                                  address_sampled,
    output logic                                  comm_enable,
    output logic                                  transmit_enable,
    output logic                                  network_activity_led,
    output logic                                  power_indicator,
    output logic                                  error_led,
    output logic                                  test_led
);
    import node_led_pkg::*;

    localparam int DIV_W = (CYCLES_PER_MS_P > 1) ? $clog2(CYCLES_PER_MS_P) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLES_PER_MS_P - 1);

    typedef struct packed {
        logic [7:0]      sync1;
        logic [7:0]      sync2;
        logic [7:0]      sync3;
        logic [7:0]      sw;
        smp_state_t      smp;
        logic [MS_W-1:0] settle;
        logic [6:0]      addr;
        logic            valid;
        logic [DIV_W-1:0] div;
        channel_t        net;
        channel_t        err;
        logic            test;
        logic            power;
        logic [31:0]     rdata;
    } state_t;

    state_t q;
    state_t d;

    ////////////////////////////////////////////////////////////////////////////////
    // Pattern sequencer shared by both LED channels

    function automatic channel_t step(input channel_t ch, input pattern_t np, input logic tick);
        channel_t       c;
        logic [MS_W-1:0] nxt;
        c   = ch;
        nxt = ch.cnt + 12'h001;
        case (ch.state)
            CH_IDLE: begin
                c.led = 1'b0;
                if (np.n != 4'h0) begin
                    c.pat   = np;
                    c.left  = np.n;
                    c.cnt   = '0;
                    c.state = CH_ON;
                    c.led   = 1'b1;
                end
            end
            CH_ON: begin
                if (tick) begin
                    if (nxt >= ch.pat.on_ms) begin
                        c.cnt  = '0;
                        c.led  = 1'b0;
                        c.left = ch.left - 4'h1;
                        if (ch.left == 4'h1) begin
                            c.state = CH_TAIL;
                        end else begin
                            c.state = CH_GAP;
                        end
                    end else begin
                        c.cnt = nxt;
                    end
                end
            end
            CH_GAP: begin
                if (tick) begin
                    if (nxt >= ch.pat.gap_ms) begin
                        c.cnt   = '0;
                        c.led   = 1'b1;
                        c.state = CH_ON;
                    end else begin
                        c.cnt = nxt;
                    end
                end
            end
            CH_TAIL: begin
                if (tick) begin
                    if (nxt >= ch.pat.tail_ms) begin
                        // Once a sequence runs, a new code is picked up only here, at sequence end (CH_IDLE also loads one)
                        c.cnt = '0;
                        if (np.n != 4'h0) begin
                            c.pat   = np;
                            c.left  = np.n;
                            c.state = CH_ON;
                            c.led   = 1'b1;
                        end else begin
                            c.state = CH_IDLE;
                        end
                    end else begin
                        c.cnt = nxt;
                    end
                end
            end
            default: begin
                c.state = CH_IDLE;
                c.led   = 1'b0;
                c.cnt   = '0;
            end
        endcase
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Combinational helpers

    logic       tick;
    logic [6:0] raw_addr;
    logic       raw_valid;
    pattern_t   net_pat;
    pattern_t   err_pat;
    logic       setup_rd;
    logic       access;
    logic       hit_ctrl;
    logic       hit_status;
    logic [31:0] status_word;

    assign tick     = (q.div == DIV_LAST);
    assign raw_addr = ({3'h0, q.sw[7:4]} << 3) + ({3'h0, q.sw[7:4]} << 1)
                      + {3'h0, q.sw[3:0]};

    always_comb begin
        raw_valid = (q.sw[7:4] <= TENS_MAX) && (q.sw[3:0] <= ONES_MAX)
                    && (raw_addr >= ADDR_MIN) && (raw_addr <= ADDR_MAX);
    end

    // Highest priority first; dark cases are handled in the next-state logic
    always_comb begin
        if (duplicate_address) begin
            net_pat = PAT_DUP;
        end else if (no_other_node) begin
            net_pat = PAT_NO_PEER;
        end else if (token_not_received) begin
            net_pat = PAT_TOKEN;
        end else if (listen_only_state) begin
            net_pat = PAT_LISTEN;
        end else if (bus_ok) begin
            net_pat = PAT_FAST;
        end else begin
            net_pat = PAT_OFF;
        end
    end

    always_comb begin
        err_pat = PAT_OFF;
        if (island_error_code == ERR_STEADY) begin
            err_pat = PAT_STEADY;
        end else if (island_error_code != 4'h0) begin
            err_pat     = PAT_STEADY;
            err_pat.n   = island_error_code;
            err_pat.tail_ms = SEQ_GAP_MS;
        end
    end

    assign setup_rd   = psel && !penable && !pwrite;
    assign access     = psel && penable;
    assign hit_ctrl   = (paddr == CTRL_OFS);
    assign hit_status = (paddr == STATUS_OFS);

    always_comb begin
        status_word                               = '0;
        status_word[ST_ADDR_LSB +: 7]             = q.addr;
        status_word[ST_VALID_BIT]                 = q.valid;
        status_word[ST_SAMPLED_BIT]               = (q.smp == SMP_HELD);
        status_word[ST_NET_N_LSB +: 4]            = q.net.pat.n;
        status_word[ST_NET_LED_BIT]               = q.net.led;
        status_word[ST_ERR_LED_BIT]               = q.err.led;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d = q;

        d.div = tick ? '0 : q.div + DIV_W'(1);

        // Three-stage switch synchroniser; a change counts once stages 2 and 3 agree
        d.sync1 = {switch_tens, switch_ones};
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        if (q.sync2 == q.sync3) begin
            d.sw = q.sync3;
        end

        case (q.smp)
            SMP_SETTLE: begin
                if (tick) begin
                    if (q.settle + 12'h001 >= SETTLE_MS) begin
                        d.addr  = raw_addr;
                        d.valid = raw_valid;
                        d.smp   = SMP_HELD;
                    end else begin
                        d.settle = q.settle + 12'h001;
                    end
                end
            end
            SMP_HELD: begin
                d.smp = SMP_HELD;
            end
            default: begin
                d.smp = SMP_SETTLE;
            end
        endcase

        if (!peer_ok || !q.valid) begin
            d.net.state = CH_IDLE;
            d.net.led   = 1'b0;
            d.net.cnt   = '0;
            d.net.pat   = PAT_OFF;
        end else begin
            d.net = step(q.net, net_pat, tick);
        end
        d.err = step(q.err, err_pat, tick);

        d.power = 1'b1;

        if (access && pwrite && hit_ctrl) begin
            d.test = pwdata[CTRL_TEST_BIT];
        end

        if (setup_rd) begin
            if (hit_ctrl) begin
                d.rdata                = '0;
                d.rdata[CTRL_TEST_BIT] = q.test;
            end else if (hit_status) begin
                d.rdata = status_word;
            end else begin
                d.rdata = '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q           <= '0;
            q.smp       <= SMP_SETTLE;
            q.net.state <= CH_IDLE;
            q.err.state <= CH_IDLE;
            q.power     <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign pready               = 1'b1;
    assign pslverr              = access && !hit_ctrl && !(hit_status && !pwrite);
    assign prdata               = q.rdata;
    assign node_address         = q.addr;
    assign address_valid        = q.valid;
    assign address_sampled      = (q.smp == SMP_HELD);
    assign comm_enable          = q.valid;
    assign transmit_enable      = q.valid && !listen_only_state;
    assign network_activity_led = q.net.led;
    assign power_indicator      = q.power;
    assign error_led            = q.err.led;
    assign test_led             = q.test;

endmodule

// >>> core/node_led_pkg.sv
package node_led_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and time base
    localparam int unsigned CLK_FREQ_HZ   = 25_000_000;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned CYCLES_PER_MS = CLK_FREQ_HZ / MS_PER_S;
    localparam int          MS_W          = 12;

    // Times in milliseconds
    localparam logic [MS_W-1:0] SETTLE_MS       = 12'h014; // 20 ms
    localparam logic [MS_W-1:0] BLINK_MS        = 12'h0c8; // 200 ms
    localparam logic [MS_W-1:0] SEQ_GAP_MS      = 12'h3e8; // 1 s
    localparam logic [MS_W-1:0] FAST_HALF_MS    = 12'h050; // 80 ms, half of 160 ms
    localparam logic [MS_W-1:0] LISTEN_TAIL_MS  = 12'h320; // 800 ms, 1 s period
    localparam logic [MS_W-1:0] TOKEN_TAIL_MS   = 12'h7d0; // 2 s
    localparam logic [MS_W-1:0] NO_PEER_TAIL_MS = 12'h6a4; // 1.7 s
    localparam logic [MS_W-1:0] DUP_TAIL_MS     = 12'h578; // 1.4 s

    ////////////////////////////////////////////////////////////////////////////////
    // Node address
    localparam logic [6:0] ADDR_MIN = 7'h01;
    localparam logic [6:0] ADDR_MAX = 7'h40;
    localparam logic [3:0] TENS_MAX = 4'h6;
    localparam logic [3:0] ONES_MAX = 4'h9;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int          PADDR_W        = 12;
    localparam logic [11:0] CTRL_OFS       = 12'h000;
    localparam logic [11:0] STATUS_OFS     = 12'h004;
    localparam int          CTRL_TEST_BIT  = 0;
    localparam int          ST_ADDR_LSB    = 0;
    localparam int          ST_VALID_BIT   = 7;
    localparam int          ST_SAMPLED_BIT = 8;
    localparam int          ST_NET_N_LSB   = 12;
    localparam int          ST_NET_LED_BIT = 16;
    localparam int          ST_ERR_LED_BIT = 17;
    localparam logic [3:0]  ERR_STEADY     = 4'hf;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [3:0] {
        CH_IDLE = 4'b0001,
        CH_ON   = 4'b0010,
        CH_GAP  = 4'b0100,
        CH_TAIL = 4'b1000
    } chan_state_t;

    typedef enum logic [1:0] {
        SMP_SETTLE = 2'b01,
        SMP_HELD   = 2'b10
    } smp_state_t;

    typedef struct packed {
        logic [3:0]      n;
        logic [MS_W-1:0] on_ms;
        logic [MS_W-1:0] gap_ms;
        logic [MS_W-1:0] tail_ms;
    } pattern_t;

    typedef struct packed {
        chan_state_t     state;
        logic [MS_W-1:0] cnt;
        logic [3:0]      left;
        pattern_t        pat;
        logic            led;
    } channel_t;

    localparam pattern_t PAT_OFF     = '{4'h0, BLINK_MS, BLINK_MS, SEQ_GAP_MS};
    localparam pattern_t PAT_FAST    = '{4'h1, FAST_HALF_MS, FAST_HALF_MS, FAST_HALF_MS};
    localparam pattern_t PAT_LISTEN  = '{4'h1, BLINK_MS, BLINK_MS, LISTEN_TAIL_MS};
    localparam pattern_t PAT_TOKEN   = '{4'h2, BLINK_MS, BLINK_MS, TOKEN_TAIL_MS};
    localparam pattern_t PAT_NO_PEER = '{4'h3, BLINK_MS, BLINK_MS, NO_PEER_TAIL_MS};
    localparam pattern_t PAT_DUP     = '{4'h4, BLINK_MS, BLINK_MS, DUP_TAIL_MS};
    localparam pattern_t PAT_STEADY  = '{4'h1, BLINK_MS, BLINK_MS, BLINK_MS};

endpackage

// >>> verif/link_state_model.sv
`timescale 1ns/1ps

// Each mode level from 1 to 6 stacks one more link condition on the lower ones
module link_state_model (
    input  wire logic [2:0] mode,
    output logic            peer_ok,
    output logic            bus_ok,
    output logic            listen_only_state,
    output logic            token_not_received,
    output logic            no_other_node,
    output logic            duplicate_address
);
    assign peer_ok            = (mode != 3'h0);
    assign bus_ok             = (mode >= 3'h2);
    assign listen_only_state  = (mode >= 3'h3);
    assign token_not_received = (mode >= 3'h4);
    assign no_other_node      = (mode >= 3'h5);
    assign duplicate_address  = (mode >= 3'h6);
endmodule

// >>> verif/node_led_chk.sv
`timescale 1ns/1ps

module node_led_chk #(
    parameter int unsigned CYCLES_PER_MS_P = 4
) (
    input wire logic                             pclk,
    input wire logic                             presetn,
    input wire logic                             psel,
    input wire logic                             penable,
    input wire logic                             pwrite,
    input wire logic [node_led_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0]                      pwdata,
    input wire logic [3:0]                       switch_tens,
    input wire logic [3:0]                       switch_ones,
    input wire logic                             peer_ok,
    input wire logic                             listen_only_state,
    input wire logic [6:0]                       node_address,
    input wire logic                             address_valid,
    input wire logic                             address_sampled,
    input wire logic                             comm_enable,
    input wire logic                             transmit_enable,
    input wire logic                             network_activity_led,
    input wire logic                             power_indicator,
    input wire logic                             error_led,
    input wire logic                             test_led
);
    import node_led_pkg::*;

    localparam int NET_LO = 79 * CYCLES_PER_MS_P;
    localparam int ERR_LO = 199 * CYCLES_PER_MS_P;
    localparam int LIT_HI = 201 * CYCLES_PER_MS_P;

    typedef struct packed {
        logic [31:0] net;
        logic [31:0] err;
    } lit_cnt_t;

    lit_cnt_t cnt_q;
    lit_cnt_t cnt_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Length of the current lit stretch of the network and error LEDs
    always_comb begin
        cnt_d.net = network_activity_led ? cnt_q.net + 32'h1 : 32'h0;
        cnt_d.err = error_led ? cnt_q.err + 32'h1 : 32'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    pwr_lit_a: assert property (power_indicator)
        else $error("power indicator dark");
    comm_gate_a: assert property (comm_enable == address_valid)
        else $error("comm enable differs from address valid");
    tx_gate_a: assert property (transmit_enable == (comm_enable && !listen_only_state))
        else $error("transmit enable wrong");
    valid_range_a: assert property (address_valid |-> node_address inside {[7'h01:7'h40]})
        else $error("valid flag on address out of range");
    bad_addr_a: assert property (address_sampled && node_address inside {7'h00, [7'h41:7'h45]}
        |-> !address_valid) else $error("invalid address flagged valid");
    addr_hold_a: assert property (address_sampled |=> address_sampled && $stable(node_address)
        && $stable(address_valid)) else $error("address changed after sampling");
    addr_form_a: assert property ($rose(address_sampled) && $past(switch_tens, 6) == switch_tens
        && $past(switch_ones, 6) == switch_ones
        |-> node_address == 7'(switch_tens * 10 + switch_ones)) else $error("address not formed");
    net_dark_a: assert property ((!peer_ok || !address_valid) [*2] |-> !network_activity_led)
        else $error("network led lit while forced dark");
    net_pulse_a: assert property ($fell(network_activity_led) && $past(peer_ok)
        |-> cnt_q.net >= NET_LO && cnt_q.net <= LIT_HI) else $error("network flash width wrong");
    err_pulse_a: assert property ($fell(error_led)
        |-> cnt_q.err >= ERR_LO && cnt_q.err <= LIT_HI) else $error("error blink width wrong");
    test_cmd_a: assert property (psel && penable && pwrite && paddr == CTRL_OFS
        |=> test_led == $past(pwdata[CTRL_TEST_BIT])) else $error("test led ignores command");
endmodule

bind node_address_and_status_led node_led_chk #(.CYCLES_PER_MS_P(CYCLES_PER_MS_P)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .switch_tens(switch_tens), .switch_ones(switch_ones),
    .peer_ok(peer_ok), .listen_only_state(listen_only_state), .node_address(node_address),
    .address_valid(address_valid), .address_sampled(address_sampled),
    .comm_enable(comm_enable), .transmit_enable(transmit_enable),
    .network_activity_led(network_activity_led), .power_indicator(power_indicator),
    .error_led(error_led), .test_led(test_led)
);

// >>> verif/tb_node_address_and_status_led.sv
`timescale 1ns/1ps

module tb_node_address_and_status_led;
    import node_led_pkg::*;

    localparam int CPM = 4;

    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [PADDR_W-1:0] paddr;
    logic [31:0]        pwdata, prdata;
    logic [3:0]         switch_tens, switch_ones, island_error_code;
    logic [2:0]         link_mode;
    logic               peer_ok, bus_ok, listen_only_state, token_not_received;
    logic               no_other_node, duplicate_address, address_valid, address_sampled;
    logic [6:0]         node_address;
    logic               comm_enable, transmit_enable, network_activity_led;
    logic               power_indicator, error_led, test_led;
    int                 n_errors = 0;
    int                 n_checks = 0;
    int                 cyc = 0;

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    node_address_and_status_led #(.CYCLES_PER_MS_P(CPM)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .switch_tens(switch_tens), .switch_ones(switch_ones), .peer_ok(peer_ok),
        .bus_ok(bus_ok), .listen_only_state(listen_only_state),
        .token_not_received(token_not_received), .no_other_node(no_other_node),
        .duplicate_address(duplicate_address), .island_error_code(island_error_code),
        .node_address(node_address), .address_valid(address_valid),
        .address_sampled(address_sampled), .comm_enable(comm_enable),
        .transmit_enable(transmit_enable), .network_activity_led(network_activity_led),
        .power_indicator(power_indicator), .error_led(error_led), .test_led(test_led)
    );

    link_state_model far (
        .mode(link_mode), .peer_ok(peer_ok), .bus_ok(bus_ok),
        .listen_only_state(listen_only_state), .token_not_received(token_not_received),
        .no_other_node(no_other_node), .duplicate_address(duplicate_address)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Phase lengths may be off by one ms tick
    function automatic logic [31:0] near(input int seen, input int exp);
        return (seen >= exp - CPM - 1 && seen <= exp + CPM + 1) ? exp : seen;
    endfunction

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic power_up(input logic [3:0] t, input logic [3:0] o);
        int c;
        presetn     <= 1'b0;
        switch_tens <= t;
        switch_ones <= o;
        repeat (12) @(posedge pclk);
        check("power lit", power_indicator, 1'b1);
        presetn <= 1'b1;
        c = 0;
        while (address_sampled !== 1'b1 && c < 400) begin
            @(posedge pclk);
            c++;
        end
        check("address sampled", address_sampled, 1'b1);
        @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic measure(input bit err, input int n, input int on_ms, input int tail_ms);
        int i;
        int c;
        c = 0;
        while ((err ? error_led : network_activity_led) !== 1'b1 && c < 2000) begin
            @(posedge pclk);
            c++;
        end
        for (i = 0; i < n; i++) begin
            c = 0;
            while ((err ? error_led : network_activity_led) === 1'b1 && c < 20000) begin
                @(posedge pclk);
                c++;
            end
            check("on time", near(c, on_ms * CPM), on_ms * CPM);
            c = 0;
            while ((err ? error_led : network_activity_led) !== 1'b1 && c < 20000) begin
                @(posedge pclk);
                c++;
            end
            c = (i == n - 1) ? c - (tail_ms - on_ms) * CPM : c;
            check(i == n - 1 ? "tail time" : "gap time", near(c, on_ms * CPM), on_ms * CPM);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_address();
        logic [7:0] tab [6] = '{8'h00, 8'h01, 8'h45, 8'h64, 8'h65, 8'h69};
        int         a;
        for (int i = 0; i < 6; i++) begin
            a = tab[i][7:4] * 10 + tab[i][3:0];
            power_up(tab[i][7:4], tab[i][3:0]);
            check("node address", node_address, a[6:0]);
            check("address valid", address_valid, a >= 1 && a <= 64);
            check("comm enable", comm_enable, a >= 1 && a <= 64);
            switch_ones <= 4'h3;
            repeat (20) @(posedge pclk);
            check("address held", node_address, a[6:0]);
        end
    endtask

    task automatic test_regs();
        logic [31:0] r;
        logic        e;
        apb(1'b1, CTRL_OFS, 32'h1, r, e);
        check("test led on", test_led, 1'b1);
        apb(1'b0, CTRL_OFS, 32'h0, r, e);
        check("test readback", r, 32'h1);
        apb(1'b0, STATUS_OFS, 32'h0, r, e);
        check("status address", r[8:0], 9'h1ad);
        apb(1'b1, STATUS_OFS, 32'h0, r, e);
        check("status write refused", e, 1'b1);
        apb(1'b0, 12'h008, 32'h0, r, e);
        check("unmapped refused", e, 1'b1);
        apb(1'b1, CTRL_OFS, 32'h0, r, e);
        check("test led off", test_led, 1'b0);
    endtask

    task automatic net_code(input logic [2:0] m, input int n, input int on_ms, input int tail_ms);
        link_mode <= 3'h0;
        repeat (4) @(posedge pclk);
        check("net dark", network_activity_led, 1'b0);
        link_mode <= m;
        measure(1'b0, n, on_ms, tail_ms);
        check("transmit gate", transmit_enable, m < 3'h3);
    endtask

    task automatic test_error();
        int c;
        island_error_code <= 4'h3;
        measure(1'b1, 3, 200, 1000);
        island_error_code <= 4'h0;
        c = 0;
        while (c < 5000) begin
            @(posedge pclk);
            c = (error_led === 1'b0) ? c + 1 : 0;
        end
        island_error_code <= ERR_STEADY;
        measure(1'b1, 2, 200, 200);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {switch_tens, switch_ones, island_error_code, link_mode} = '0;
        test_address();
        power_up(4'h4, 4'h5);
        test_regs();
        net_code(3'h6, 4, 200, 1400);
        net_code(3'h5, 3, 200, 1700);
        net_code(3'h4, 2, 200, 2000);
        net_code(3'h3, 1, 200, 800);
        net_code(3'h2, 1, 80, 80);
        test_error();
        end_sim();
    end
endmodule
